// ---- src/jtp_fifo.sv ----
// Shift-down word buffer: entry 0 is always the head, so outputs are flops.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
`default_nettype none
module jtp_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Filling side
    jtp_fifo_if.snk wr,
    // Draining side
    output logic [W-1:0] rd_data,
    output logic rd_valid,
    input wire logic rd_ready
);
    logic [W-1:0] mem_q [D];
    logic [D-1:0] vld_q;
    logic [D-1:0] vld_d;
    logic [D:0] vld_hi;
    logic [D:0] vld_lo;
    logic rdy_q;
    logic pop;
    logic push;

    // Handshakes on both sides
    assign pop = vld_q[0] & rd_ready;
    assign push = wr.valid & rdy_q;
    assign vld_hi = {1'b0, vld_q};
    assign vld_lo = {vld_q, 1'b1};

    // Each entry shifts down on a pop; a push lands in the first free slot
    for (genvar i = 0; i < D; i++) begin : g_ent
        logic keep_v;
        logic below_v;
        logic wr_here;
        assign keep_v = pop ? vld_hi[i+1] : vld_q[i];
        assign below_v = pop ? vld_hi[i] : vld_lo[i];
        assign wr_here = push & ~keep_v & below_v;
        assign vld_d[i] = keep_v | wr_here;
        always_ff @(posedge clk or negedge nrst) begin
            if (!nrst) begin
                mem_q[i] <= '0;
            end else if (wr_here) begin
                mem_q[i] <= wr.data;
            end else if (pop) begin
                mem_q[i] <= mem_q[(i+1) % D];
            end
        end
    end

    // Occupancy and registered room flag, so full is honest one cycle ahead
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            vld_q <= '0;
            rdy_q <= 1'b1;
        end else begin
            vld_q <= vld_d;
            rdy_q <= ~vld_d[D-1];
        end
    end

    assign wr.ready = rdy_q;
    assign rd_data = mem_q[0];
    assign rd_valid = vld_q[0];

endmodule : jtp_fifo
`default_nettype wire

// ---- src/jtp_fifo_if.sv ----
// Push channel between the controller and the update word buffer.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none
interface jtp_fifo_if #(parameter int W = 8);
    logic [W-1:0] data;
    logic valid;
    logic ready;
    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);
endinterface : jtp_fifo_if
`default_nettype wire

// ---- src/jtp_pkg.sv ----
// Constants, pin map and state encoding shared by the test access port block.
// Assumes one system clock domain that samples every test port pin.
package jtp_pkg;

    // Instruction register, data register and update buffer sizes
    localparam int IR_W = 3;
    localparam int IDC_W = 32;
    localparam int BSR_W = 8;
    localparam int FIFO_DEPTH = 8;

    // Instruction codes
    localparam logic [IR_W-1:0] IR_EXTEST = 3'h0;
    localparam logic [IR_W-1:0] IR_IDCODE = 3'h1;
    localparam logic [IR_W-1:0] IR_SAMPLE = 3'h4;
    localparam logic [IR_W-1:0] IR_HIGHZ = 3'h5;

    // Identification value: arbitrary, only the lsb of one is fixed
    localparam logic [IDC_W-1:0] IDCODE_VAL = 32'h1234_5001;

    // Bit positions in the synchroniser vector and their reset levels
    localparam int PIN_N = 5;
    localparam int PIN_TCK = 0;
    localparam int PIN_TMS = 1;
    localparam int PIN_TDI = 2;
    localparam int PIN_TRST = 3;
    localparam int PIN_STRAP = 4;
    localparam logic [PIN_N-1:0] PIN_RST = 5'h1e;

    // Rising edges with mode select high that force the reset state
    localparam logic [2:0] TMS_RESET_EDGES = 3'h5;

    // Controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001, ST_RTI = 16'h0002, ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008, ST_SH_DR = 16'h0010, ST_EX1_DR = 16'h0020,
        ST_PA_DR = 16'h0040, ST_EX2_DR = 16'h0080, ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200, ST_CAP_IR = 16'h0400, ST_SH_IR = 16'h0800,
        ST_EX1_IR = 16'h1000, ST_PA_IR = 16'h2000, ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } jtp_state_e;

endpackage : jtp_pkg

// ---- src/jtp_tap_top.sv ----
// Test access port front end: pin sampling, 16-state controller,
// instruction and data shift paths, pin sharing with the debug port.
// Assumes clk is far faster than the test clock, which is sampled as data.
`timescale 1ns/10ps
`default_nettype none
module jtp_tap_top
    import jtp_pkg::*;
(
    // System clock and master reset
    input wire logic clk,
    input wire logic nrst,
    // Test port pins; *_drv is high while the far end drives the pin
    input wire logic tck_pin,
    input wire logic tms_pin,
    input wire logic tms_drv,
    input wire logic tdi_pin,
    input wire logic tdi_drv,
    input wire logic trst_n_pin,
    input wire logic trst_drv,
    output logic tdo_q,
    output logic tdo_oe_q,
    // Port function strap
    input wire logic test_port_select_strap,
    // Debug module side
    input wire logic debug_serial_out,
    output logic hw_breakpoint_request_q,
    output logic debug_serial_in_q,
    output logic debug_serial_clock_q,
    // Boundary-scan side
    input wire logic [BSR_W-1:0] bsr_capture,
    output logic extest_en_q,
    output logic pins_highz_q,
    output logic [BSR_W-1:0] bsr_upd_data,
    output logic bsr_upd_valid,
    input wire logic bsr_upd_ready,
    output logic bsr_upd_room_q,
    output logic bsr_overrun_q
);

    logic tms_eff, tdi_eff, trst_eff;
    logic [PIN_N-1:0] pin_raw;
    logic [PIN_N-1:0] sync1_q;
    logic [PIN_N-1:0] sync2_q;
    logic tck_s, tms_s, tdi_s, dbg_clk_s, jtag_mode;
    logic tck_old_q;
    logic tck_rise, tck_fall;
    logic trst_s1_q, trst_s2_q;
    logic tap_arst_n, tap_rst_n;
    jtp_state_e state_q;
    logic [IR_W-1:0] ir_sr_q;
    logic [IR_W-1:0] instr_q;
    logic byp_q;
    logic [IDC_W-1:0] idc_sr_q;
    logic [BSR_W-1:0] bsr_sr_q;
    logic sel_bsr, sel_idc;
    logic dr_lsb;
    logic push_q;
    logic [BSR_W-1:0] upd_q;
    logic [2:0] ones_q;

    jtp_fifo_if #(.W(BSR_W)) upd_if ();

    // Weak pull-ups: a pin nobody drives reads high
    assign tms_eff = tms_drv ? tms_pin : 1'b1;
    assign tdi_eff = tdi_drv ? tdi_pin : 1'b1;
    assign trst_eff = trst_drv ? trst_n_pin : 1'b1;

    // Two-flop synchronisers; the first stage feeds only the second
    assign pin_raw = {test_port_select_strap, trst_eff, tdi_eff, tms_eff, tck_pin};
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_q <= PIN_RST;
            sync2_q <= PIN_RST;
        end else begin
            sync1_q <= pin_raw;
            sync2_q <= sync1_q;
        end
    end

    assign tck_s = sync2_q[PIN_TCK];
    assign tms_s = sync2_q[PIN_TMS];
    assign tdi_s = sync2_q[PIN_TDI];
    assign dbg_clk_s = sync2_q[PIN_TRST];
    assign jtag_mode = sync2_q[PIN_STRAP];

    // Test clock edge detection on the synchronised level
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tck_old_q <= 1'b0;
        end else begin
            tck_old_q <= tck_s;
        end
    end

    assign tck_rise = tck_s & ~tck_old_q;
    assign tck_fall = ~tck_s & tck_old_q;

    // Test reset asserts asynchronously and releases in step with clk,
    // so the controller never sees a half-released reset
    assign tap_arst_n = nrst & trst_eff;
    always_ff @(posedge clk or negedge tap_arst_n) begin
        if (!tap_arst_n) begin
            trst_s1_q <= 1'b0;
            trst_s2_q <= 1'b0;
        end else begin
            trst_s1_q <= 1'b1;
            trst_s2_q <= trst_s1_q;
        end
    end

    assign tap_rst_n = trst_s2_q;

    // Standard state graph; mode select decides each step
    function automatic jtp_state_e tap_next(input jtp_state_e s, input logic m);
        jtp_state_e n;
        n = ST_TLR;
        case (s)
            ST_TLR: n = m ? ST_TLR : ST_RTI;
            ST_RTI: n = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_DR: n = m ? ST_SEL_IR : ST_CAP_DR;
            ST_CAP_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_SH_DR: n = m ? ST_EX1_DR : ST_SH_DR;
            ST_EX1_DR: n = m ? ST_UPD_DR : ST_PA_DR;
            ST_PA_DR: n = m ? ST_EX2_DR : ST_PA_DR;
            ST_EX2_DR: n = m ? ST_UPD_DR : ST_SH_DR;
            ST_UPD_DR: n = m ? ST_SEL_DR : ST_RTI;
            ST_SEL_IR: n = m ? ST_TLR : ST_CAP_IR;
            ST_CAP_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_SH_IR: n = m ? ST_EX1_IR : ST_SH_IR;
            ST_EX1_IR: n = m ? ST_UPD_IR : ST_PA_IR;
            ST_PA_IR: n = m ? ST_EX2_IR : ST_PA_IR;
            ST_EX2_IR: n = m ? ST_UPD_IR : ST_SH_IR;
            ST_UPD_IR: n = m ? ST_SEL_DR : ST_RTI;
            default: n = ST_TLR;
        endcase
        return n;
    endfunction : tap_next

    // Controller; held in reset while the pins serve the debug port
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            state_q <= ST_TLR;
        end else if (!jtag_mode) begin
            state_q <= ST_TLR;
        end else if (tck_rise) begin
            state_q <= tap_next(state_q, tms_s);
        end
    end

    // Instruction shift stage: capture loads the identification code
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ir_sr_q <= IR_IDCODE;
        end else if (tck_rise && state_q == ST_CAP_IR) begin
            ir_sr_q <= IR_IDCODE;
        end else if (tck_rise && state_q == ST_SH_IR) begin
            ir_sr_q <= {tdi_s, ir_sr_q[IR_W-1:1]};
        end
    end

    // Instruction hold stage, loaded on the fall in Update-IR
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            instr_q <= IR_IDCODE;
        end else if (state_q == ST_TLR) begin
            instr_q <= IR_IDCODE;
        end else if (tck_fall && state_q == ST_UPD_IR) begin
            instr_q <= ir_sr_q;
        end
    end

    // Data register selection; unlisted codes fall back to bypass
    assign sel_bsr = (instr_q == IR_EXTEST) || (instr_q == IR_SAMPLE);
    assign sel_idc = (instr_q == IR_IDCODE);

    // Data path: capture then shift with the input bit entering at the msb
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            byp_q <= 1'b0;
            idc_sr_q <= IDCODE_VAL;
            bsr_sr_q <= '0;
        end else if (tck_rise && state_q == ST_CAP_DR) begin
            byp_q <= 1'b0;
            idc_sr_q <= IDCODE_VAL;
            bsr_sr_q <= bsr_capture;
        end else if (tck_rise && state_q == ST_SH_DR) begin
            byp_q <= tdi_s;
            if (sel_idc) begin
                idc_sr_q <= {tdi_s, idc_sr_q[IDC_W-1:1]};
            end
            if (sel_bsr) begin
                bsr_sr_q <= {tdi_s, bsr_sr_q[BSR_W-1:1]};
            end
        end
    end

    assign dr_lsb = sel_bsr ? bsr_sr_q[0] : (sel_idc ? idc_sr_q[0] : byp_q);

    // Output pin: test data on the fall, or the debug serial bit.
    // Runs on master reset so the debug port works while the TAP is held.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tdo_q <= 1'b0;
            tdo_oe_q <= 1'b0;
        end else if (!jtag_mode) begin
            tdo_q <= debug_serial_out;
            tdo_oe_q <= 1'b1;
        end else if (state_q == ST_TLR) begin
            tdo_oe_q <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_q <= (state_q == ST_SH_IR) || (state_q == ST_SH_DR);
            tdo_q <= (state_q == ST_SH_IR) ? ir_sr_q[0] : dr_lsb;
        end
    end

    // Debug port functions of the shared pins; breakpoint pin is active low
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hw_breakpoint_request_q <= 1'b0;
            debug_serial_in_q <= 1'b0;
            debug_serial_clock_q <= 1'b0;
        end else begin
            hw_breakpoint_request_q <= ~jtag_mode & ~tms_s;
            debug_serial_in_q <= ~jtag_mode & tdi_s;
            debug_serial_clock_q <= ~jtag_mode & dbg_clk_s;
        end
    end

    // Pin control from the held instruction; idle under the reset state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            extest_en_q <= 1'b0;
            pins_highz_q <= 1'b0;
        end else begin
            extest_en_q <= jtag_mode & (instr_q == IR_EXTEST);
            pins_highz_q <= jtag_mode & (instr_q == IR_HIGHZ);
        end
    end

    // Update word push: one cycle, on the fall in Update-DR
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            push_q <= 1'b0;
            upd_q <= '0;
        end else begin
            push_q <= tck_fall & (state_q == ST_UPD_DR) & sel_bsr;
            if (tck_fall && state_q == ST_UPD_DR) begin
                upd_q <= bsr_sr_q;
            end
        end
    end

    assign upd_if.valid = push_q;
    assign upd_if.data = upd_q;

    // The test clock cannot be stalled, so a push that meets a full buffer
    // is dropped and flagged; a new drop wins over the clear
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bsr_overrun_q <= 1'b0;
            bsr_upd_room_q <= 1'b1;
        end else begin
            bsr_upd_room_q <= upd_if.ready;
            if (push_q && !upd_if.ready) begin
                bsr_overrun_q <= 1'b1;
            end else if (state_q == ST_TLR) begin
                bsr_overrun_q <= 1'b0;
            end
        end
    end

    jtp_fifo #(.W(BSR_W), .D(FIFO_DEPTH)) u_fifo (
        .clk(clk),
        .nrst(nrst),
        .wr(upd_if.snk),
        .rd_data(bsr_upd_data),
        .rd_valid(bsr_upd_valid),
        .rd_ready(bsr_upd_ready)
    );

    // Helper for checks: consecutive rising edges seen with mode select high
    always_ff @(posedge clk or negedge tap_rst_n) begin
        if (!tap_rst_n) begin
            ones_q <= 3'h0;
        end else if (tck_rise) begin
            if (!tms_s) begin
                ones_q <= 3'h0;
            end else if (ones_q != TMS_RESET_EDGES) begin
                ones_q <= ones_q + 3'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!tap_rst_n);

    sequence s_rise_hi;
        tck_rise && tms_s;
    endsequence
    sequence s_tlr_twice;
        state_q == ST_TLR ##1 state_q == ST_TLR;
    endsequence
    sequence s_undriven3;
        !tms_drv [*3];
    endsequence

    a_state_onehot: assert property ($onehot(state_q))
        else $error("controller state not one-hot");
    a_hold_no_edge: assert property (!tck_rise && jtag_mode |=> $stable(state_q))
        else $error("state moved without a test clock rise");
    a_five_ones: assert property (s_rise_hi and ones_q == 3'h4 |=> state_q == ST_TLR)
        else $error("reset state not reached after five high edges");
    a_tlr_to_idle: assert property (
        state_q == ST_TLR && tck_rise && !tms_s && jtag_mode |=> state_q == ST_RTI)
        else $error("reset state did not leave to idle");
    a_shift_dr_hold: assert property (
        state_q == ST_SH_DR && tck_rise && !tms_s |=> state_q == ST_SH_DR)
        else $error("shift data state left with mode select low");
    a_ir_capture: assert property (
        state_q == ST_CAP_IR && tck_rise |=> ir_sr_q == IR_IDCODE)
        else $error("instruction capture value wrong");
    a_ir_shift_in: assert property (
        state_q == ST_SH_IR && tck_rise |=> ir_sr_q[IR_W-1] == $past(tdi_s))
        else $error("instruction msb did not take the input bit");
    a_ir_update: assert property (
        state_q == ST_UPD_IR && tck_fall |=> instr_q == $past(ir_sr_q))
        else $error("hold stage not loaded on update fall");
    a_tlr_idcode: assert property (state_q == ST_TLR |=> instr_q == IR_IDCODE)
        else $error("reset state did not select identification code");
    a_tlr_inert: assert property (s_tlr_twice |=> !extest_en_q && !pins_highz_q)
        else $error("pin control active in reset state");
    a_tdo_release: assert property (
        jtag_mode && state_q == ST_TLR |=> !tdo_oe_q)
        else $error("data output driven outside shift");
    a_tdo_fall: assert property (
        jtag_mode && state_q == ST_SH_IR && tck_fall |=> tdo_oe_q && tdo_q == $past(ir_sr_q[0]))
        else $error("data output not updated on fall");
    a_tms_pullup: assert property (@(posedge clk) disable iff (!nrst)
        s_undriven3 |=> ##1 tms_s)
        else $error("undriven mode select not read high");
    a_tdi_pullup: assert property (@(posedge clk) disable iff (!nrst)
        !tdi_drv [*3] |=> ##1 tdi_s)
        else $error("undriven data input not read high");
    a_debug_mux: assert property (@(posedge clk) disable iff (!nrst)
        !jtag_mode |=> debug_serial_in_q == $past(tdi_s) && tdo_oe_q)
        else $error("debug port pins not routed");

endmodule : jtp_tap_top
`default_nettype wire

// ---- tb/jtp_tap_top_tb_top.sv ----
// Self-checking bench for the test access port front end.
// Assumes the host model in jtp_tester and the design package.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin num_errors++; \
    $display("BAD %s exp %h got %h", nm, ex, got); end end
module jtp_tap_top_tb_top
    import jtp_pkg::*;
();
    logic clk, nrst, strap, dbg_out, ready;
    logic tck, tms, tms_drv, tdi, tdi_drv, trst, trst_drv, tdo, tdo_oe;
    logic hbr, dsi, dsc, ext, hiz, upd_valid, room, ovr, e_bit;
    logic [BSR_W-1:0] cap, upd_data, e_word;
    logic [31:0] rng;
    int num_errors, checks_done, cycles;
    logic exp_tdo[$];
    logic [BSR_W-1:0] exp_word[$];

    // Free-running 200 MHz clock
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    jtp_tester tst (.clk(clk), .tck_pin(tck), .tms_pin(tms), .tms_drv(tms_drv), .tdi_pin(tdi),
        .tdi_drv(tdi_drv), .trst_n_pin(trst), .trst_drv(trst_drv));

    jtp_tap_top dut (.clk(clk), .nrst(nrst), .tck_pin(tck), .tms_pin(tms), .tms_drv(tms_drv),
        .tdi_pin(tdi), .tdi_drv(tdi_drv), .trst_n_pin(trst), .trst_drv(trst_drv), .tdo_q(tdo),
        .tdo_oe_q(tdo_oe), .test_port_select_strap(strap), .debug_serial_out(dbg_out),
        .hw_breakpoint_request_q(hbr), .debug_serial_in_q(dsi), .debug_serial_clock_q(dsc),
        .bsr_capture(cap), .extest_en_q(ext), .pins_highz_q(hiz), .bsr_upd_data(upd_data),
        .bsr_upd_valid(upd_valid), .bsr_upd_ready(ready), .bsr_upd_room_q(room),
        .bsr_overrun_q(ovr));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs

    task automatic print_verdict();
        $display("checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict

    // Output data is judged where a host samples it, on the clock rise
    always @(posedge tck) begin
        if (tdo_oe !== 1'b0) begin
            if (exp_tdo.size() == 0) `CHK("tdo_oe", 1'b0, tdo_oe)
            else begin
                e_bit = exp_tdo.pop_front();
                `CHK("tdo", e_bit, tdo)
            end
        end
    end

    // Buffer words are taken off the note queue as the consumer accepts them
    always @(posedge clk) begin
        if (upd_valid === 1'b1 && ready === 1'b1) begin
            e_word = exp_word.pop_front();
            `CHK("bsr_upd_data", e_word, upd_data)
        end
    end

    // Hang guard, far above the few thousand cycles the tests need
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            print_verdict();
        end
    end

    // Instruction load: the captured 001 comes out lsb first
    task automatic load_ir(input logic [IR_W-1:0] code);
        for (int i = 0; i < IR_W; i++) exp_tdo.push_back(IR_IDCODE[i]);
        tst.scan(1'b1, IR_W, {29'h0, code});
        repeat (6) @(posedge clk);
    endtask : load_ir

    task automatic scan_dr(input int n, input logic [31:0] cv, input logic [31:0] d);
        for (int i = 0; i < n; i++) exp_tdo.push_back(cv[i]);
        tst.scan(1'b0, n, d);
    endtask : scan_dr

    // Main sequence
    initial begin
        nrst = 1'b0;
        strap = 1'b1;
        dbg_out = 1'b0;
        ready = 1'b0;
        cap = 8'h00;
        rng = 32'hc68dfb6c;
        num_errors = 0;
        checks_done = 0;
        cycles = 0;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        repeat (6) @(posedge clk);
        tst.bit_cyc(1'b0, 1'b1);
        load_ir(IR_EXTEST);
        `CHK("extest_en", 1'b1, ext)
        `CHK("pins_highz", 1'b0, hiz)
        load_ir(IR_HIGHZ);
        `CHK("pins_highz", 1'b1, hiz)
        rng = xs(rng);
        scan_dr(8, {rng[30:0], 1'b0}, rng);
        load_ir(IR_SAMPLE);
        `CHK("extest_en", 1'b0, ext)
        for (int k = 0; k <= FIFO_DEPTH; k++) begin
            rng = xs(rng);
            @(posedge clk);
            cap <= rng[15:8];
            scan_dr(BSR_W, {24'h0, rng[15:8]}, {24'h0, rng[7:0]});
            if (k < FIFO_DEPTH) exp_word.push_back(rng[7:0]);
        end
        repeat (4) @(posedge clk);
        `CHK("overrun", 1'b1, ovr)
        `CHK("room", 1'b0, room)
        for (int k = 0; k < 32; k++) begin
            @(posedge clk);
            rng = xs(rng);
            ready <= rng[0];
        end
        @(posedge clk);
        ready <= 1'b1;
        repeat (8) @(posedge clk);
        `CHK("words_left", 0, exp_word.size())
        `CHK("room", 1'b1, room)
        load_ir(IR_EXTEST);
        tst.bit_cyc(1'b1, 1'b1);
        tst.bit_cyc(1'b0, 1'b1);
        tst.bit_cyc(1'b1, 1'b1);
        exp_word.push_back(cap); // Update-DR passes on the way to reset
        tst.free_tms();
        repeat (6) @(posedge clk);
        `CHK("extest_en", 1'b0, ext)
        `CHK("overrun", 1'b0, ovr)
        tst.bit_cyc(1'b0, 1'b1);
        load_ir(IR_EXTEST);
        tst.trst_pulse();
        `CHK("extest_en", 1'b0, ext)
        tst.bit_cyc(1'b0, 1'b1);
        scan_dr(IDC_W, IDCODE_VAL, 32'h0);
        `CHK("tdo_left", 0, exp_tdo.size())
        @(posedge clk);
        strap <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            rng = xs(rng);
            @(posedge clk);
            dbg_out <= rng[3];
            tst.dbg(rng[0], rng[1], rng[2]);
            #1;
            `CHK("hw_breakpoint", ~rng[0], hbr)
            `CHK("debug_in", rng[1], dsi)
            `CHK("debug_clock", rng[2], dsc)
            `CHK("tdo_debug", rng[3], tdo)
        end
        print_verdict();
    end
endmodule : jtp_tap_top_tb_top
`default_nettype wire

// ---- tb/jtp_tester.sv ----
// Host model: drives test clock, mode select, data in and test reset.
// Assumes the device samples these pins with its own faster clock.
`timescale 1ns/10ps
`default_nettype none
module jtp_tester (
    // System clock, only to place pin changes
    input wire logic clk,
    // Test port pins
    output logic tck_pin,
    output logic tms_pin,
    output logic tms_drv,
    output logic tdi_pin,
    output logic tdi_drv,
    output logic trst_n_pin,
    output logic trst_drv
);
    // Idle: clock stands low, data in and test reset released
    initial begin
        tck_pin = 1'b0;
        tms_pin = 1'b1;
        tms_drv = 1'b1;
        tdi_pin = 1'b0;
        tdi_drv = 1'b0;
        trst_n_pin = 1'b1;
        trst_drv = 1'b0;
    end

    // One 65 ns test clock period; odd offset keeps it out of step with clk
    task automatic bit_cyc(input logic ms, input logic di);
        @(posedge clk);
        tms_pin <= ms;
        tdi_pin <= di;
        tdi_drv <= 1'b1;
        #31.3 tck_pin = 1'b1;
        #32 tck_pin = 1'b0;
    endtask : bit_cyc

    // Scan n bits from idle and back; ir picks the instruction path
    task automatic scan(input logic ir, input int n, input logic [31:0] d);
        bit_cyc(1'b1, 1'b1);
        if (ir) bit_cyc(1'b1, 1'b1);
        bit_cyc(1'b0, 1'b1);
        bit_cyc(1'b0, 1'b1);
        for (int i = 0; i < n; i++) bit_cyc(i == n - 1, d[i]);
        bit_cyc(1'b1, 1'b1);
        bit_cyc(1'b0, 1'b1);
        @(posedge clk);
        tdi_drv <= 1'b0;
        tdi_pin <= ~tdi_pin; // Stale level must not leak through the pull-up
    endtask : scan

    // Five rises with mode select left undriven and a low stale level
    task automatic free_tms();
        @(posedge clk);
        tms_drv <= 1'b0;
        repeat (5) bit_cyc(1'b0, 1'b1);
        @(posedge clk);
        tms_drv <= 1'b1;
        tms_pin <= 1'b1;
    endtask : free_tms

    // Test reset pulse, released only while mode select is high
    task automatic trst_pulse();
        @(posedge clk);
        tms_pin <= 1'b1;
        trst_drv <= 1'b1;
        trst_n_pin <= 1'b0;
        repeat (4) @(posedge clk);
        trst_drv <= 1'b0;
        trst_n_pin <= 1'b0; // Stale low: only the pull-up can release reset
    endtask : trst_pulse

    // Debug use: one pin change per five clk keeps the serial clock slow
    task automatic dbg(input logic ms, input logic di, input logic sc);
        @(posedge clk);
        tms_pin <= ms;
        tdi_pin <= di;
        tdi_drv <= 1'b1;
        trst_drv <= 1'b1;
        trst_n_pin <= sc;
        repeat (4) @(posedge clk);
    endtask : dbg
endmodule : jtp_tester
`default_nettype wire
